// ### logic/ssf_framer.sv
// Sync channel framer: labels every word slot on the sync channel and drives 32 data lanes.
// Assumes window geometry and kernel pixels come from a sequencer on ref_clk, and that the
// host link clock arrives asynchronously; one word slot is emitted per link clock rising edge.
`timescale 1ns/1ps
module ssf_framer #(
  parameter int LANES = 32,
  parameter int KERNEL = 64
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic adc_mode8,
  input wire logic [7:0] reg_addr,
  input wire logic reg_we,
  input wire logic [ssf_pkg::DW-1:0] reg_wdata,
  output logic [ssf_pkg::DW-1:0] reg_rdata,
  input wire logic frame_start,
  input wire logic [4:0] win_id,
  input wire logic [6:0] win_kernels,
  input wire logic [12:0] win_lines,
  input wire logic [ssf_pkg::DW-1:0] comp_offset,
  input wire logic [KERNEL*ssf_pkg::DW-1:0] kern_pix,
  output logic kern_take,
  output logic kern_black,
  output logic slot_strobe,
  output logic [ssf_pkg::DW-1:0] sync_word,
  output logic [LANES*ssf_pkg::DW-1:0] lane_word,
  output logic frame_busy
);
  import ssf_pkg::*;

  if (KERNEL != 2 * LANES || LANES < 1) begin : g_bad_geometry
    $error("ssf_framer: KERNEL must equal two pixels per lane");
  end

  function automatic logic [DW-1:0] cls(input logic [DW-1:0] v, input logic m8);
    cls = m8 ? {2'h0, v[9:2]} : v;
  endfunction : cls

  function automatic logic [DW-1:0] marker(input logic [2:0] t, input logic [6:0] c,
                                          input logic m8);
    marker = m8 ? {2'h0, t, c[6:2]} : {t, c};
  endfunction : marker

  function automatic logic [DW-1:0] id_word(input logic [4:0] id, input logic m8);
    id_word = m8 ? {3'h0, id, 2'h0} : {5'h00, id};
  endfunction : id_word

  function automatic logic [DW-1:0] crc_step(input logic [DW-1:0] c, input logic [DW-1:0] d,
                                            input logic m8);
    logic [DW-1:0] r;
    logic fb;
    r = c;
    fb = 1'b0;
    for (int i = DW - 1; i >= 0; i--) begin
      if (m8) begin
        if (i < 8) begin
          fb = r[7] ^ d[i];
          r = {2'h0, r[6:0], 1'b0};
          if (fb) r = r ^ POLY8;
        end
      end else begin
        fb = r[9] ^ d[i];
        r = {r[8:0], 1'b0};
        if (fb) r = r ^ POLY10;
      end
    end
    crc_step = r;
  endfunction : crc_step

  ////////////////////////////////////////////////////////////////////////////////
  // Link clock and mode pin sampling.
  logic [2:0] lk_sync_reg;
  logic lk_level_reg;
  logic [2:0] m8_sync_reg;
  logic m8_reg;
  logic slot_en;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lk_sync_reg <= 3'h0;
      lk_level_reg <= 1'b0;
    end else begin
      lk_sync_reg <= {lk_sync_reg[1:0], link_clk};
      if (lk_sync_reg[1] == lk_sync_reg[2]) lk_level_reg <= lk_sync_reg[2];
    end
  end

  assign slot_en = lk_sync_reg[1] & lk_sync_reg[2] & ~lk_level_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      m8_sync_reg <= 3'h0;
      m8_reg <= 1'b0;
    end else begin
      m8_sync_reg <= {m8_sync_reg[1:0], adc_mode8};
      if (m8_sync_reg[1] == m8_sync_reg[2]) m8_reg <= m8_sync_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  logic [DW-1:0] data_idle_pattern_reg;
  logic [6:0] sync_code_reg;
  logic [DW-1:0] black_class_code_reg;
  logic [DW-1:0] image_class_code_reg;
  logic [DW-1:0] check_class_code_reg;
  logic [DW-1:0] idle_class_code_reg;
  logic [2:0] config_reg;
  logic [12:0] black_lines_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      data_idle_pattern_reg <= RST_DATA_IDLE;
      sync_code_reg <= RST_SYNC_CODE;
      black_class_code_reg <= RST_BLACK_CLASS;
      image_class_code_reg <= RST_IMAGE_CLASS;
      check_class_code_reg <= RST_CHECK_CLASS;
      idle_class_code_reg <= RST_IDLE_CLASS;
      config_reg <= RST_CONFIG;
      black_lines_reg <= RST_BLACK_LINES;
    end else if (reg_we) begin
      case (reg_addr)
        ADDR_DATA_IDLE: data_idle_pattern_reg <= reg_wdata;
        ADDR_SYNC_CODE: sync_code_reg <= reg_wdata[6:0];
        ADDR_BLACK_CLASS: black_class_code_reg <= reg_wdata;
        ADDR_IMAGE_CLASS: image_class_code_reg <= reg_wdata;
        ADDR_CHECK_CLASS: check_class_code_reg <= reg_wdata;
        ADDR_IDLE_CLASS: idle_class_code_reg <= reg_wdata;
        ADDR_CONFIG: config_reg <= reg_wdata[2:0];
        ADDR_BLACK_LINES: black_lines_reg <= {3'h0, reg_wdata};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line sequencing.
  ssf_state_t st_reg;
  logic frame_pend_reg;
  logic frame_run_reg;
  logic in_black_reg;
  logic first_reg;
  logic half_reg;
  logic [6:0] kern_idx_reg;
  logic [12:0] black_left_reg;
  logic [12:0] lines_left_reg;
  logic [6:0] line_len;
  logic last_line;
  logic first_line;
  logic line_done;

  // Global shutter black lines ignore the window width entirely.
  assign line_len = (in_black_reg && config_reg[CFG_GLOBAL]) ? FULL_LINE_KERNELS :
                    win_kernels;
  assign last_line = !in_black_reg && lines_left_reg == 13'h0001;
  assign first_line = !in_black_reg && first_reg;
  assign line_done = half_reg && kern_idx_reg == line_len - 7'h01;
  assign frame_busy = frame_run_reg;
  assign kern_take = slot_en && st_reg == ST_DATA && !half_reg;
  assign kern_black = in_black_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_pend_reg <= 1'b0;
    end else if (frame_start) begin
      frame_pend_reg <= 1'b1;
    end else if (slot_en && st_reg == ST_IDLE && !frame_run_reg) begin
      frame_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= ST_IDLE;
      frame_run_reg <= 1'b0;
      in_black_reg <= 1'b0;
      first_reg <= 1'b0;
      half_reg <= 1'b0;
      kern_idx_reg <= 7'h00;
      black_left_reg <= 13'h0000;
      lines_left_reg <= 13'h0000;
    end else if (slot_en) begin
      case (st_reg)
        ST_IDLE: begin
          if (frame_run_reg) begin
            st_reg <= ST_MARK0;
          end else if (frame_pend_reg) begin
            frame_run_reg <= 1'b1;
            in_black_reg <= 1'b1;
            first_reg <= 1'b1;
            black_left_reg <= (black_lines_reg == 13'h0000) ? 13'h0001 :
                              black_lines_reg;
            lines_left_reg <= win_lines;
          end
        end
        ST_MARK0: st_reg <= ST_ID0;
        ST_ID0: begin
          st_reg <= ST_DATA;
          half_reg <= 1'b0;
          kern_idx_reg <= 7'h00;
        end
        ST_DATA: begin
          half_reg <= ~half_reg;
          if (half_reg) kern_idx_reg <= kern_idx_reg + 7'h01;
          if (line_done) st_reg <= ST_MARK1;
        end
        ST_MARK1: st_reg <= ST_ID1;
        ST_ID1: st_reg <= ST_CRC;
        ST_CRC: begin
          st_reg <= ST_IDLE;
          if (in_black_reg) begin
            black_left_reg <= black_left_reg - 13'h0001;
            if (black_left_reg == 13'h0001) begin
              in_black_reg <= 1'b0;
              if (lines_left_reg == 13'h0000) frame_run_reg <= 1'b0;
            end
          end else begin
            first_reg <= 1'b0;
            lines_left_reg <= lines_left_reg - 13'h0001;
            if (last_line) frame_run_reg <= 1'b0;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sync channel word.
  logic [DW-1:0] sync_next;
  logic [2:0] mk_open;
  logic [2:0] mk_close;

  // Black lines never open or close a frame.
  assign mk_open = first_line ? MK_FRAME_BEGIN : MK_LINE_BEGIN;
  assign mk_close = last_line ? MK_FRAME_FINISH : MK_LINE_FINISH;

  always_comb begin
    sync_next = cls(idle_class_code_reg, m8_reg);
    case (st_reg)
      ST_IDLE: sync_next = cls(idle_class_code_reg, m8_reg);
      ST_MARK0: sync_next = marker(mk_open, sync_code_reg, m8_reg);
      ST_ID0: sync_next = id_word(win_id, m8_reg);
      ST_DATA: sync_next = in_black_reg ? cls(black_class_code_reg, m8_reg) :
                           cls(image_class_code_reg, m8_reg);
      ST_MARK1: sync_next = marker(mk_close, sync_code_reg, m8_reg);
      ST_ID1: sync_next = id_word(win_id, m8_reg);
      ST_CRC: sync_next = cls(check_class_code_reg, m8_reg);
      default: sync_next = cls(idle_class_code_reg, m8_reg);
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_word <= RST_IDLE_CLASS;
      slot_strobe <= 1'b0;
    end else begin
      slot_strobe <= slot_en;
      if (slot_en) sync_word <= sync_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data lanes.
  logic [KERNEL*DW-1:0] kern_reg;
  logic [KERNEL*DW-1:0] kern_src;

  always_ff @(posedge ref_clk) begin
    if (reset) kern_reg <= '0;
    else if (kern_take) kern_reg <= kern_pix;
  end

  assign kern_src = half_reg ? kern_reg : kern_pix;

  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      logic [DW-1:0] pix;
      logic [DW-1:0] comp;
      logic [DW-1:0] word;
      logic [DW-1:0] lane_next;
      logic [DW-1:0] crc_reg;
      always_comb begin
        pix = '0;
        case ({kern_idx_reg[0], half_reg})
          2'h0: pix = kern_src[(2 * l) * DW +: DW];
          2'h1: pix = kern_src[(2 * l + 1) * DW +: DW];
          2'h2: pix = kern_src[(KERNEL - 1 - 2 * l) * DW +: DW];
          2'h3: pix = kern_src[(KERNEL - 2 - 2 * l) * DW +: DW];
          default: pix = '0;
        endcase
      end
      // Compensation saturates at zero rather than wrapping dark pixels to white.
      assign comp = (in_black_reg || config_reg[CFG_BYPASS]) ? pix :
                    (pix > comp_offset) ? pix - comp_offset : '0;
      assign word = m8_reg ? {2'h0, comp[9:2]} : comp;
      always_comb begin
        lane_next = m8_reg ? {2'h0, data_idle_pattern_reg[9:2]} :
                    data_idle_pattern_reg;
        if (st_reg == ST_DATA) lane_next = word;
        else if (st_reg == ST_CRC) lane_next = crc_reg;
      end
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          crc_reg <= '0;
          lane_word[l * DW +: DW] <= RST_DATA_IDLE;
        end else if (slot_en) begin
          lane_word[l * DW +: DW] <= lane_next;
          if (st_reg == ST_MARK0) crc_reg <= config_reg[CFG_SEED] ? '1 : '0;
          else if (st_reg == ST_DATA) crc_reg <= crc_step(crc_reg, word, m8_reg);
        end
      end
      if (l == 0) begin : g_chk
        a_lane_check: assert property (@(posedge ref_clk) disable iff (reset)
          slot_en && st_reg == ST_CRC |=> lane_word[DW-1:0] == $past(crc_reg))
          else $error("lane 0 did not send its check value");
        a_crc_seed: assert property (@(posedge ref_clk) disable iff (reset)
          slot_en && st_reg == ST_MARK0 |=> crc_reg == (config_reg[CFG_SEED] ? '1 : '0))
          else $error("check value not seeded at line start");
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Register read back.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        ADDR_DATA_IDLE: reg_rdata <= data_idle_pattern_reg;
        ADDR_SYNC_CODE: reg_rdata <= {3'h0, sync_code_reg};
        ADDR_BLACK_CLASS: reg_rdata <= black_class_code_reg;
        ADDR_IMAGE_CLASS: reg_rdata <= image_class_code_reg;
        ADDR_CHECK_CLASS: reg_rdata <= check_class_code_reg;
        ADDR_IDLE_CLASS: reg_rdata <= idle_class_code_reg;
        ADDR_CONFIG: reg_rdata <= {7'h00, config_reg};
        ADDR_BLACK_LINES: reg_rdata <= black_lines_reg[DW-1:0];
        ADDR_STATUS: reg_rdata <= {m8_reg, in_black_reg, frame_run_reg, st_reg};
        default: reg_rdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_line_open;
    slot_en && st_reg == ST_MARK0 && in_black_reg;
  endsequence

  a_idle_class: assert property (@(posedge ref_clk) disable iff (reset)
    slot_en && st_reg == ST_IDLE |=>
      sync_word == cls($past(idle_class_code_reg), $past(m8_reg)) &&
      lane_word[DW-1:0] == ($past(m8_reg) ? {2'h0, $past(data_idle_pattern_reg[9:2])} :
                            $past(data_idle_pattern_reg)))
    else $error("idle slot not labelled idle with training word");
  a_check_class: assert property (@(posedge ref_clk) disable iff (reset)
    slot_en && st_reg == ST_CRC |=> sync_word == cls(check_class_code_reg, m8_reg))
    else $error("check slot not labelled");
  a_black_begin: assert property (@(posedge ref_clk) disable iff (reset)
    s_line_open |=> (m8_reg ? sync_word[7:5] : sync_word[9:7]) == MK_LINE_BEGIN)
    else $error("black line opened with a frame marker");
  a_id_follow: assert property (@(posedge ref_clk) disable iff (reset)
    slot_en && st_reg == ST_ID0 |=> sync_word == id_word(win_id, m8_reg))
    else $error("window number missing after marker");
  a_black_min: assert property (@(posedge ref_clk) disable iff (reset)
    slot_en && st_reg == ST_IDLE && !frame_run_reg && frame_pend_reg |=>
      in_black_reg && black_left_reg != 13'h0000)
    else $error("frame started without a black line");
  a_black_len: assert property (@(posedge ref_clk) disable iff (reset)
    slot_en && st_reg == ST_DATA && half_reg && in_black_reg && config_reg[CFG_GLOBAL] |=>
      ($past(kern_idx_reg) == FULL_LINE_KERNELS - 7'h01) == (st_reg == ST_MARK1))
    else $error("global shutter black line not full width");
  a_data_class: assert property (@(posedge ref_clk) disable iff (reset)
    slot_en && st_reg == ST_DATA && !in_black_reg |=>
      sync_word == cls(image_class_code_reg, m8_reg))
    else $error("image slot mislabelled");
  a_slot_align: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(sync_word) |-> $past(slot_en))
    else $error("sync word changed outside a slot");
endmodule : ssf_framer

// ### logic/ssf_pkg.sv
// Constants shared by the sync channel framer: register offsets, reset values and codes.
// Assumes an 8-bit register address space reached by a write/read port from a serial loader.
package ssf_pkg;
  localparam int DW = 10;
  localparam logic [7:0] ADDR_DATA_IDLE = 8'h82;
  localparam logic [7:0] ADDR_SYNC_CODE = 8'h83;
  localparam logic [7:0] ADDR_BLACK_CLASS = 8'h84;
  localparam logic [7:0] ADDR_IMAGE_CLASS = 8'h85;
  localparam logic [7:0] ADDR_CHECK_CLASS = 8'h86;
  localparam logic [7:0] ADDR_IDLE_CLASS = 8'h87;
  localparam logic [7:0] ADDR_CONFIG = 8'h88;
  localparam logic [7:0] ADDR_BLACK_LINES = 8'h89;
  localparam logic [7:0] ADDR_STATUS = 8'h8a;
  localparam logic [9:0] RST_DATA_IDLE = 10'h3a6;
  localparam logic [6:0] RST_SYNC_CODE = 7'h2a;
  localparam logic [9:0] RST_BLACK_CLASS = 10'h015;
  localparam logic [9:0] RST_IMAGE_CLASS = 10'h035;
  localparam logic [9:0] RST_CHECK_CLASS = 10'h059;
  localparam logic [9:0] RST_IDLE_CLASS = 10'h3a6;
  localparam logic [2:0] RST_CONFIG = 3'h0;
  localparam logic [12:0] RST_BLACK_LINES = 13'h0001;
  localparam int CFG_SEED = 0;
  localparam int CFG_BYPASS = 1;
  localparam int CFG_GLOBAL = 2;
  localparam logic [2:0] MK_FRAME_BEGIN = 3'h5;
  localparam logic [2:0] MK_FRAME_FINISH = 3'h6;
  localparam logic [2:0] MK_LINE_BEGIN = 3'h1;
  localparam logic [2:0] MK_LINE_FINISH = 3'h2;
  localparam logic [9:0] POLY10 = 10'h24f;
  localparam logic [9:0] POLY8 = 10'h04d;
  localparam logic [6:0] FULL_LINE_KERNELS = 7'h50;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_MARK0 = 7'h02,
    ST_ID0 = 7'h04,
    ST_DATA = 7'h08,
    ST_MARK1 = 7'h10,
    ST_ID1 = 7'h20,
    ST_CRC = 7'h40
  } ssf_state_t;
endpackage : ssf_pkg

// ### verification/ssf_framer_test.sv
// Self-checking bench for the sync channel framer: registers, idle output and whole frames.
// Assumes the receiver model records every slot and drives the link clock.
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module ssf_framer_test;
  import ssf_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic adc_mode8 = 1'b0;
  logic link_clk;
  logic [7:0] reg_addr = 8'h00;
  logic reg_we = 1'b0;
  logic [9:0] reg_wdata = 10'h000;
  logic [9:0] reg_rdata;
  logic frame_start = 1'b0;
  logic [4:0] win_id = 5'h00;
  logic [6:0] win_kernels = 7'h01;
  logic [12:0] win_lines = 13'h0001;
  logic [9:0] comp_offset = 10'h000;
  logic [639:0] kern_pix = '0;
  logic kern_take, kern_black, slot_strobe, frame_busy;
  logic [9:0] sync_word;
  logic [319:0] lane_word;
  int miscompares = 0;
  int comparisons = 0;
  logic [31:0] st = 32'd60;
  logic [7:0] ad[5] = '{ADDR_DATA_IDLE, ADDR_BLACK_CLASS, ADDR_IMAGE_CLASS, ADDR_CHECK_CLASS,
    ADDR_IDLE_CLASS};
  logic [9:0] rv[5] = '{10'h3a6, 10'h015, 10'h035, 10'h059, 10'h3a6};
  logic [9:0] cv[5];
  logic [6:0] scode = 7'h2a;
  logic seed, byp;
  logic [639:0] kern_q[$];
  ssf_framer ssf_framer_i (.ref_clk(ref_clk), .reset(reset), .link_clk(link_clk),
    .adc_mode8(adc_mode8), .reg_addr(reg_addr), .reg_we(reg_we), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frame_start(frame_start), .win_id(win_id),
    .win_kernels(win_kernels), .win_lines(win_lines), .comp_offset(comp_offset),
    .kern_pix(kern_pix), .kern_take(kern_take), .kern_black(kern_black),
    .slot_strobe(slot_strobe), .sync_word(sync_word), .lane_word(lane_word),
    .frame_busy(frame_busy));
  ssf_receiver ssf_receiver_i (.ref_clk(ref_clk), .slot_strobe(slot_strobe),
    .sync_word(sync_word), .lane_word(lane_word), .link_clk(link_clk));
  ////////////////////////////////////////////////////////////////////////////////
  always #20 ref_clk = ~ref_clk;
  always @(negedge ref_clk) for (int i = 0; i < 20; i++) kern_pix[i * 32 +: 32] = rnd();
  always @(posedge ref_clk) if (kern_take === 1'b1) kern_q.push_back(kern_pix);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction : rnd
  function automatic logic [9:0] cls(input logic [9:0] v);
    return adc_mode8 ? {2'h0, v[9:2]} : v;
  endfunction : cls
  function automatic logic [9:0] mark(input logic [2:0] t);
    return adc_mode8 ? {2'h0, t, scode[6:2]} : {t, scode};
  endfunction : mark
  function automatic logic [9:0] idw();
    return adc_mode8 ? {3'h0, win_id, 2'h0} : {5'h0, win_id};
  endfunction : idw
  function automatic logic [9:0] crc(input logic [9:0] c0, input logic [9:0] w);
    logic [9:0] c;
    logic fb;
    int n;
    c = c0;
    n = adc_mode8 ? 8 : 10;
    for (int i = n - 1; i >= 0; i--) begin
      fb = c[n - 1] ^ w[i];
      c = {c[8:0], 1'b0} & (adc_mode8 ? 10'h0ff : 10'h3ff);
      if (fb) c = c ^ (adc_mode8 ? POLY8 : POLY10);
    end
    return c;
  endfunction : crc
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [9:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge ref_clk);
    reg_we = 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [9:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    repeat (2) @(negedge ref_clk);
    d = reg_rdata;
  endtask : rdr
  task automatic pop(output logic [9:0] s, output logic [319:0] l);
    s = '0;
    l = '0;
    if (ssf_receiver_i.sq.size() > 0) begin
      s = ssf_receiver_i.sq.pop_front();
      l = ssf_receiver_i.lq.pop_front();
    end
  endtask : pop
  task automatic chk_line(input logic blk, input logic [2:0] t0, input logic [2:0] t1,
      input int nk);
    logic [9:0] s, p;
    logic [319:0] l, e, c;
    logic [639:0] kp;
    int n;
    pop(s, l);
    n = 0;
    while (s === cls(cv[4]) && n < 60) begin
      `CHK(l, {32{cls(cv[0])}})
      pop(s, l);
      n++;
    end
    `CHK(s, mark(t0))
    `CHK(l, {32{cls(cv[0])}})
    pop(s, l);
    // The identifier after a black line marker carries no meaning for the far end.
    if (!blk) `CHK(s, idw())
    c = {32{seed ? (adc_mode8 ? 10'h0ff : 10'h3ff) : 10'h000}};
    for (int k = 0; k < nk; k++) begin
      kp = (kern_q.size() > 0) ? kern_q.pop_front() : '0;
      for (int h = 0; h < 2; h++) begin
        pop(s, l);
        `CHK(s, cls(blk ? cv[1] : cv[2]))
        for (int ln = 0; ln < 32; ln++) begin
          p = kp[(k % 2 == 1 ? 63 - 2 * ln - h : 2 * ln + h) * 10 +: 10];
          if (!blk && !byp) p = (p >= comp_offset) ? p - comp_offset : 10'h000;
          p = cls(p);
          e[ln * 10 +: 10] = p;
          c[ln * 10 +: 10] = crc(c[ln * 10 +: 10], p);
        end
        `CHK(l, e)
      end
    end
    pop(s, l);
    `CHK(s, mark(t1))
    pop(s, l);
    if (!blk) `CHK(s, idw())
    pop(s, l);
    `CHK(s, cls(cv[3]))
    `CHK(l, c)
  endtask : chk_line
  task automatic setup(input logic m, input logic rc, input logic [2:0] cfg,
      input logic [9:0] nb);
    logic [9:0] rd;
    @(negedge ref_clk);
    adc_mode8 = m;
    seed = cfg[0];
    byp = cfg[1];
    if (rc) begin
      cv[0] = 10'(rnd());
      for (int i = 1; i < 4; i++) cv[i] = 10'(rnd()) & 10'h1ff;
      // Idle code kept apart from marker and data codes so idle gaps can be told apart.
      cv[4] = 10'(rnd()) | 10'h380;
      scode = 7'(rnd());
    end
    for (int i = 0; i < 5; i++) begin
      wr(ad[i], cv[i]);
      rdr(ad[i], rd);
      `CHK(rd, cv[i])
    end
    wr(ADDR_SYNC_CODE, {3'h0, scode});
    wr(ADDR_CONFIG, {7'h0, cfg});
    wr(ADDR_BLACK_LINES, nb);
    comp_offset = 10'(rnd()) & 10'h0ff;
    win_id = 5'(rnd());
    repeat (8) @(negedge ref_clk);
  endtask : setup
  task automatic frame(input int nb, input int nl, input int nk, input logic gl);
    logic [9:0] s;
    logic [319:0] l;
    int i;
    win_kernels = 7'(nk);
    win_lines = 13'(nl);
    ssf_receiver_i.sq.delete();
    ssf_receiver_i.lq.delete();
    kern_q.delete();
    frame_start = 1'b1;
    @(negedge ref_clk);
    frame_start = 1'b0;
    i = 0;
    while (frame_busy !== 1'b1 && i < 100) begin
      @(negedge ref_clk);
      i++;
    end
    `CHK(frame_busy, 1'b1)
    `CHK(kern_black, 1'b1)
    while (frame_busy !== 1'b0 && i < 40000) begin
      @(negedge ref_clk);
      i++;
    end
    `CHK(frame_busy, 1'b0)
    `CHK(kern_black, 1'b0)
    repeat (64) @(negedge ref_clk);
    for (int b = 0; b < nb; b++) begin
      chk_line(1'b1, MK_LINE_BEGIN, MK_LINE_FINISH, gl ? 80 : nk);
    end
    for (int j = 0; j < nl; j++) chk_line(1'b0, j == 0 ? MK_FRAME_BEGIN : MK_LINE_BEGIN,
      j == nl - 1 ? MK_FRAME_FINISH : MK_LINE_FINISH, nk);
    while (ssf_receiver_i.sq.size() > 0) begin
      pop(s, l);
      `CHK(s, cls(cv[4]))
      `CHK(l, {32{cls(cv[0])}})
    end
  endtask : frame
  task automatic report_and_stop();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [9:0] rd;
    cv = rv;
    repeat (8) @(negedge ref_clk);
    reset = 1'b0;
    repeat (40) @(negedge ref_clk);
    `CHK(sync_word, 10'h3a6)
    `CHK(lane_word, {32{10'h3a6}})
    for (int i = 0; i < 5; i++) begin
      rdr(ad[i], rd);
      `CHK(rd, rv[i])
    end
    rdr(ADDR_SYNC_CODE, rd);
    `CHK(rd, 10'h02a)
    wr(8'h00, 10'h155);
    rdr(8'h00, rd);
    `CHK(rd, 10'h000)
    rdr(ADDR_STATUS, rd);
    `CHK(rd, {3'h0, ST_IDLE})
    // A count of zero must still give one black line.
    setup(1'b0, 1'b0, 3'h0, 10'h000);
    frame(1, 2, 2, 1'b0);
    setup(1'b1, 1'b1, 3'h7, 10'h002);
    frame(2, 1, 3, 1'b1);
    setup(1'b0, 1'b1, 3'h1, 10'h001);
    frame(1, 3, 1, 1'b0);
    report_and_stop();
  end
  // Three short frames take under 10,000 clocks; a hang is cut off at 100,000.
  initial begin
    #4000000;
    miscompares++;
    report_and_stop();
  end
endmodule : ssf_framer_test

// ### verification/ssf_receiver.sv
// Receiver model for the sync channel framer: makes the host link clock and records slots.
// Assumes slot_strobe marks the one cycle in which a new sync and lane word set is shown.
`timescale 1ns/1ps
module ssf_receiver (
  input wire logic ref_clk,
  input wire logic slot_strobe,
  input wire logic [ssf_pkg::DW-1:0] sync_word,
  input wire logic [32*ssf_pkg::DW-1:0] lane_word,
  output logic link_clk
);
  import ssf_pkg::*;
  logic [DW-1:0] sq[$];
  logic [32*DW-1:0] lq[$];
  ////////////////////////////////////////////////////////////////////////////////
  // The host clock runs free, so the far end can keep training between frames.
  initial begin
    link_clk = 1'b0;
    #37;
    forever #160 link_clk = ~link_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Sync and lanes are taken as one unit so a label always sits with its data.
  always @(posedge ref_clk) begin
    if (slot_strobe === 1'b1) begin
      sq.push_back(sync_word);
      lq.push_back(lane_word);
    end
  end
endmodule : ssf_receiver
